// ---- core/modcfg_pkg.sv ----
// package for the modulator configuration and status register bank
// assumes a single processing clock; registers are 8 bits wide
package modcfg_pkg;
    // control register indices
    localparam logic [3:0] ADDR_INPUT_CTRL = 4'h5;
    localparam logic [3:0] ADDR_GAIN_LO = 4'h6;
    localparam logic [3:0] ADDR_GAIN_HI = 4'h7;
    localparam logic [3:0] ADDR_FREQ_B0 = 4'h8;
    localparam logic [3:0] ADDR_FREQ_B1 = 4'h9;
    localparam logic [3:0] ADDR_FREQ_B2 = 4'ha;
    localparam logic [3:0] ADDR_FREQ_B3 = 4'hb;
    localparam logic [3:0] ADDR_OUT_SEL = 4'hc;
    localparam logic [3:0] ADDR_BUS_ADDR = 4'hd;
    // status register indices
    localparam logic [3:0] ADDR_USB_CNT_B0 = 4'h0;
    localparam logic [3:0] ADDR_USB_CNT_B1 = 4'h1;
    localparam logic [3:0] ADDR_USB_CNT_B2 = 4'h2;
    localparam logic [3:0] ADDR_USB_CNT_B3 = 4'h3;
    // field positions in the input and test control register
    localparam int TEST_MODE_LSB = 0;
    localparam int SRC_SEL_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // input source codes
    localparam logic [1:0] SRC_DIRECT_SERIAL = 2'h0;
    localparam logic [1:0] SRC_DIRECT_PARALLEL = 2'h1;
    localparam logic [1:0] SRC_USB_PARALLEL = 2'h2;
    localparam logic [1:0] SRC_BUS_SERIAL = 2'h3;
    // test mode codes
    localparam logic [1:0] TEST_OFF = 2'h0;
    localparam logic [1:0] TEST_PRBS = 2'h1;
    localparam logic [1:0] TEST_CARRIER = 2'h2;
    // output select codes and their sample rates in Msamples/s
    localparam logic [2:0] OSEL_U10_40 = 3'h0;
    localparam logic [2:0] OSEL_S14_50 = 3'h1;
    localparam logic [2:0] OSEL_U10_90 = 3'h2;
    localparam logic [7:0] RATE_40 = 8'h28;
    localparam logic [7:0] RATE_50 = 8'h32;
    localparam logic [7:0] RATE_90 = 8'h5a;
    // input bus: broadcast address, data bit positions
    localparam logic [3:0] BUS_BROADCAST = 4'hf;
    localparam int BUS_SAMPLE_BIT = 0;
    localparam int BUS_DATA_BIT = 1;
    localparam int BUS_REQ_BIT = 0;
    // pseudo_random_test_sequence: 11-stage register, taps 11 and 9
    localparam logic [10:0] PRBS_SEED = 11'h7ff;
    localparam int PRBS_TAP_A = 10;
    localparam int PRBS_TAP_B = 8;
    // capture buffer
    localparam int CAP_DEPTH = 512;
    localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// ---- core/modulator_config_status_regs.sv ----
// modulator register bank: input select, serialiser, counter, capture
// assumes all ports on ref_clk except connector and bus pins (synchronised)
//
// Summary of operation
// - source 00 serial, 01 parallel direct
// - source 10 usb bytes, 11 bus serial
// - parallel bytes serialised msb first
// - test mode ignores external input
// - gain is 16 bits, low then high
// - saturation flag shown on probe point
// - frequency word is signed 32 bits
// - frequency word from four bytes, lsb first
// - select 0: unsigned 10-bit, 40 Msps
// - select 1: signed 14-bit, 50 Msps
// - select 2: unsigned 10-bit, 90 Msps
// - 4-bit bus address, used on bus only
// - bus access on address match; writes also on broadcast
// - address write resets output interface
// - status registers are read only
// - usb byte counter 32 bits, wraps
// - counter read as four status bytes
// - capture 512 signed 8-bit samples
// - capture rate by decimation or clock
// - control registers read back as written
// - everything runs on processing clock
`timescale 1ns/1ps
module modulator_config_status_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic reg_status_sel,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    input wire logic [7:0] data_in,
    input wire logic sample_clk_in,
    output logic sample_clk_in_req,
    input wire logic bus_clk_in,
    input wire logic [3:0] bus_addr,
    input wire logic bus_rwn,
    input wire logic [15:0] bus_data_in,
    output logic [15:0] bus_data_out,
    output logic bus_data_oe_n,
    input wire logic usb_byte_valid,
    input wire logic [7:0] usb_byte,
    input wire logic mod_bit_ready,
    output logic mod_bit,
    output logic mod_bit_valid,
    output logic carrier_only,
    output logic [15:0] signal_gain,
    output logic [31:0] centre_freq_word,
    output logic [9:0] out_sample_width,
    output logic out_signed,
    output logic out_resample_en,
    output logic [7:0] out_rate_msps,
    output logic out_if_reset,
    input wire logic interp_saturated,
    output logic saturation_probe_point,
    input wire logic [7:0] trace_sample,
    input wire logic trace_native_strobe,
    input wire logic capture_start,
    input wire logic [7:0] capture_decimation,
    input wire logic capture_at_clk,
    input wire logic [8:0] capture_rd_addr,
    output logic [7:0] capture_rd_data,
    output logic capture_busy
);

    ////////////////////////////////////////////////////////////////////////
    // control registers
    logic [7:0] input_and_test_control_reg;
    logic [7:0] gain_low_byte_reg;
    logic [7:0] gain_high_byte_reg;
    logic [7:0] centre_freq_byte0_reg;
    logic [7:0] centre_freq_byte1_reg;
    logic [7:0] centre_freq_byte2_reg;
    logic [7:0] centre_freq_byte3_reg;
    logic [7:0] output_select_reg;
    logic [7:0] input_bus_slave_address_reg;
    logic [1:0] src_sel;
    logic [1:0] test_mode;

    assign src_sel = input_and_test_control_reg[modcfg_pkg::SRC_SEL_LSB +: 2];
    assign test_mode = input_and_test_control_reg[modcfg_pkg::TEST_MODE_LSB +: 2];

    // writes land only in the control space; status space ignores them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {input_and_test_control_reg, gain_low_byte_reg, gain_high_byte_reg,
                centre_freq_byte0_reg, centre_freq_byte1_reg, centre_freq_byte2_reg,
                centre_freq_byte3_reg, output_select_reg, input_bus_slave_address_reg}
                <= {9{modcfg_pkg::CTRL_RESET}};
        end else if (reg_wr_en && !reg_status_sel) begin
            case (reg_addr)
                modcfg_pkg::ADDR_INPUT_CTRL: input_and_test_control_reg <= reg_wr_data;
                modcfg_pkg::ADDR_GAIN_LO: gain_low_byte_reg <= reg_wr_data;
                modcfg_pkg::ADDR_GAIN_HI: gain_high_byte_reg <= reg_wr_data;
                modcfg_pkg::ADDR_FREQ_B0: centre_freq_byte0_reg <= reg_wr_data;
                modcfg_pkg::ADDR_FREQ_B1: centre_freq_byte1_reg <= reg_wr_data;
                modcfg_pkg::ADDR_FREQ_B2: centre_freq_byte2_reg <= reg_wr_data;
                modcfg_pkg::ADDR_FREQ_B3: centre_freq_byte3_reg <= reg_wr_data;
                modcfg_pkg::ADDR_OUT_SEL: output_select_reg <= reg_wr_data;
                modcfg_pkg::ADDR_BUS_ADDR: input_bus_slave_address_reg <= reg_wr_data;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // usb byte counter with snapshot for coherent multi-byte reads
    logic [31:0] usb_count_reg;
    logic [31:0] usb_snap_reg;
    logic snap_take;

    // reading byte0 freezes the whole count for the following bytes
    assign snap_take = reg_rd_en && reg_status_sel && (reg_addr == modcfg_pkg::ADDR_USB_CNT_B0);

    // natural overflow gives the wrap to zero after all ones
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            usb_count_reg <= '0;
        end else if (usb_byte_valid) begin
            usb_count_reg <= usb_count_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            usb_snap_reg <= '0;
        end else if (snap_take) begin
            usb_snap_reg <= usb_count_reg;
        end
    end

    // read mux; byte0 comes live since it is the snapshot moment
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rd_data <= '0;
        end else if (reg_rd_en && reg_status_sel) begin
            case (reg_addr)
                modcfg_pkg::ADDR_USB_CNT_B0: reg_rd_data <= usb_count_reg[7:0];
                modcfg_pkg::ADDR_USB_CNT_B1: reg_rd_data <= usb_snap_reg[15:8];
                modcfg_pkg::ADDR_USB_CNT_B2: reg_rd_data <= usb_snap_reg[23:16];
                modcfg_pkg::ADDR_USB_CNT_B3: reg_rd_data <= usb_snap_reg[31:24];
                default: reg_rd_data <= '0;
            endcase
        end else if (reg_rd_en) begin
            case (reg_addr)
                modcfg_pkg::ADDR_INPUT_CTRL: reg_rd_data <= input_and_test_control_reg;
                modcfg_pkg::ADDR_GAIN_LO: reg_rd_data <= gain_low_byte_reg;
                modcfg_pkg::ADDR_GAIN_HI: reg_rd_data <= gain_high_byte_reg;
                modcfg_pkg::ADDR_FREQ_B0: reg_rd_data <= centre_freq_byte0_reg;
                modcfg_pkg::ADDR_FREQ_B1: reg_rd_data <= centre_freq_byte1_reg;
                modcfg_pkg::ADDR_FREQ_B2: reg_rd_data <= centre_freq_byte2_reg;
                modcfg_pkg::ADDR_FREQ_B3: reg_rd_data <= centre_freq_byte3_reg;
                modcfg_pkg::ADDR_OUT_SEL: reg_rd_data <= output_select_reg;
                modcfg_pkg::ADDR_BUS_ADDR: reg_rd_data <= input_bus_slave_address_reg;
                default: reg_rd_data <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // datapath settings; frequency word is f * 2^32 / fclk, taken as written
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            signal_gain <= '0;
            centre_freq_word <= '0;
            saturation_probe_point <= 1'b0;
        end else begin
            signal_gain <= {gain_high_byte_reg, gain_low_byte_reg};
            centre_freq_word <= {centre_freq_byte3_reg, centre_freq_byte2_reg,
                centre_freq_byte1_reg, centre_freq_byte0_reg};
            saturation_probe_point <= interp_saturated;
        end
    end

    // width, signed, resample, rate; unknown codes act as code 0
    function automatic logic [19:0] out_format(input logic [2:0] code);
        case (code)
            modcfg_pkg::OSEL_S14_50: return {10'h00e, 2'b11, modcfg_pkg::RATE_50};
            modcfg_pkg::OSEL_U10_90: return {10'h00a, 2'b00, modcfg_pkg::RATE_90};
            default: return {10'h00a, 2'b01, modcfg_pkg::RATE_40};
        endcase
    endfunction

    // output format decode, code 0 during reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            {out_sample_width, out_signed, out_resample_en, out_rate_msps} <= out_format(3'h0);
        end else begin
            {out_sample_width, out_signed, out_resample_en, out_rate_msps}
                <= out_format(output_select_reg[2:0]);
        end
    end

    // one-cycle reset of the output interface on any address write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_if_reset <= 1'b0;
        end else begin
            out_if_reset <= reg_wr_en && !reg_status_sel
                && (reg_addr == modcfg_pkg::ADDR_BUS_ADDR);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage one feeds stage two only
    logic [7:0] din_s1_reg, din_s2_reg;
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic bclk_s1_reg, bclk_s2_reg, bclk_s3_reg;
    logic [3:0] baddr_s1_reg, baddr_s2_reg;
    logic brwn_s1_reg, brwn_s2_reg;
    logic [1:0] bdat_s1_reg, bdat_s2_reg;

    always_ff @(posedge ref_clk) begin
        {din_s1_reg, sclk_s1_reg, bclk_s1_reg, baddr_s1_reg, brwn_s1_reg, bdat_s1_reg} <= {data_in,
            sample_clk_in, bus_clk_in, bus_addr, bus_rwn, bus_data_in[modcfg_pkg::BUS_DATA_BIT],
            bus_data_in[modcfg_pkg::BUS_SAMPLE_BIT]};
        {din_s2_reg, sclk_s2_reg, bclk_s2_reg, baddr_s2_reg, brwn_s2_reg, bdat_s2_reg} <=
            {din_s1_reg, sclk_s1_reg, bclk_s1_reg, baddr_s1_reg, brwn_s1_reg, bdat_s1_reg};
        {sclk_s3_reg, bclk_s3_reg} <= {sclk_s2_reg, bclk_s2_reg};
    end

    ////////////////////////////////////////////////////////////////////////
    // input source selection
    logic direct_strobe, bus_edge, bus_hit, bus_write, bus_read;
    logic src_valid, src_is_byte, ext_enabled;
    logic [7:0] src_byte;

    // strobe pulses are wider than our period, so take the rising edge
    assign direct_strobe = sclk_s2_reg && !sclk_s3_reg;
    assign bus_edge = bclk_s2_reg && !bclk_s3_reg;
    // only the low nibble is the address; broadcast applies to writes only
    assign bus_hit = baddr_s2_reg == input_bus_slave_address_reg[3:0];
    assign bus_write = bus_edge && !brwn_s2_reg
        && (bus_hit || baddr_s2_reg == modcfg_pkg::BUS_BROADCAST);
    assign bus_read = bus_edge && brwn_s2_reg && bus_hit;
    assign ext_enabled = test_mode == modcfg_pkg::TEST_OFF;

    always_comb begin
        src_valid = 1'b0;
        src_is_byte = 1'b0;
        src_byte = '0;
        case (src_sel)
            modcfg_pkg::SRC_DIRECT_SERIAL: begin
                src_valid = direct_strobe;
                src_byte = {din_s2_reg[0], 7'h00};
            end
            modcfg_pkg::SRC_DIRECT_PARALLEL: begin
                src_valid = direct_strobe;
                src_is_byte = 1'b1;
                src_byte = din_s2_reg;
            end
            modcfg_pkg::SRC_USB_PARALLEL: begin
                src_valid = usb_byte_valid;
                src_is_byte = 1'b1;
                src_byte = usb_byte;
            end
            modcfg_pkg::SRC_BUS_SERIAL: begin
                src_valid = bus_write && bdat_s2_reg[0];
                src_byte = {bdat_s2_reg[1], 7'h00};
            end
            default: ;
        endcase
        src_valid = src_valid && ext_enabled;
    end

    ////////////////////////////////////////////////////////////////////////
    // serialiser: one byte or one bit held, shifted out msb first
    logic [7:0] shift_reg;
    logic [3:0] bits_left_reg;
    logic shift_empty;

    assign shift_empty = bits_left_reg == 4'h0;

    // a new word is accepted only once the previous one has drained
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shift_reg <= '0;
            bits_left_reg <= '0;
        end else if (shift_empty && src_valid) begin
            shift_reg <= src_byte;
            bits_left_reg <= src_is_byte ? modcfg_pkg::BYTE_BITS : 4'h1;
        end else if (!shift_empty && mod_bit_ready && !mod_bit_valid) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            bits_left_reg <= bits_left_reg - 4'h1;
        end
    end

    // pseudo_random_test_sequence generator, steps once per bit taken
    logic [10:0] prbs_reg;
    always_ff @(posedge ref_clk) begin
        if (reset || test_mode != modcfg_pkg::TEST_PRBS) begin
            prbs_reg <= modcfg_pkg::PRBS_SEED;
        end else if (mod_bit_ready && !mod_bit_valid) begin
            prbs_reg <= {prbs_reg[9:0],
                prbs_reg[modcfg_pkg::PRBS_TAP_A] ^ prbs_reg[modcfg_pkg::PRBS_TAP_B]};
        end
    end

    // bit stream out: test sequence, carrier (no bits) or external data
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mod_bit <= 1'b0;
            mod_bit_valid <= 1'b0;
            carrier_only <= 1'b0;
        end else begin
            carrier_only <= test_mode == modcfg_pkg::TEST_CARRIER;
            mod_bit_valid <= 1'b0;
            if (mod_bit_ready && !mod_bit_valid) begin
                if (test_mode == modcfg_pkg::TEST_PRBS) begin
                    mod_bit <= prbs_reg[modcfg_pkg::PRBS_TAP_A];
                    mod_bit_valid <= 1'b1;
                end else if (ext_enabled && !shift_empty) begin
                    mod_bit <= shift_reg[7];
                    mod_bit_valid <= 1'b1;
                end
            end
        end
    end

    // flow control toward direct source and bus master
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sample_clk_in_req <= 1'b0;
            bus_data_out <= '0;
            bus_data_oe_n <= 1'b1;
        end else begin
            sample_clk_in_req <= shift_empty && ext_enabled && !src_valid
                && !src_sel[1] && !sample_clk_in_req;
            if (bus_read && src_sel == modcfg_pkg::SRC_BUS_SERIAL) begin
                bus_data_out <= '0;
                bus_data_out[modcfg_pkg::BUS_REQ_BIT] <= shift_empty && ext_enabled;
                bus_data_oe_n <= 1'b0;
            end else if (bus_edge) begin
                bus_data_oe_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture: 512 samples, native strobe or every clock, both decimated
    logic [7:0] cap_mem [0:modcfg_pkg::CAP_DEPTH-1];
    logic [8:0] cap_wr_ptr_reg;
    logic [7:0] decim_cnt_reg;
    logic cap_tick;

    assign cap_tick = capture_busy && (capture_at_clk || trace_native_strobe)
        && decim_cnt_reg == 8'h00;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            decim_cnt_reg <= '0;
        end else if (!capture_busy) begin
            decim_cnt_reg <= '0;
        end else if (capture_at_clk || trace_native_strobe) begin
            decim_cnt_reg <= (decim_cnt_reg >= capture_decimation) ? 8'h00
                : decim_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cap_wr_ptr_reg <= '0;
            capture_busy <= 1'b0;
        end else if (capture_start && !capture_busy) begin
            cap_wr_ptr_reg <= '0;
            capture_busy <= 1'b1;
        end else if (cap_tick) begin
            cap_wr_ptr_reg <= cap_wr_ptr_reg + 9'h001;
            if (cap_wr_ptr_reg == 9'h1ff) begin
                capture_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (cap_tick) begin
            cap_mem[cap_wr_ptr_reg] <= trace_sample;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            capture_rd_data <= '0;
        end else begin
            capture_rd_data <= cap_mem[capture_rd_addr];
        end
    end

endmodule

// ---- dv/modcfg_assertions.sv ----
// concurrent checks on settings outputs and bit stream
// assumes ref_clk only, synchronous active-high reset
`timescale 1ns/1ps
module modcfg_checker (
    input logic ref_clk,
    input logic reset,
    input logic [3:0] reg_addr,
    input logic reg_status_sel,
    input logic reg_wr_en,
    input logic [7:0] reg_wr_data,
    input logic mod_bit_valid,
    input logic carrier_only,
    input logic [15:0] signal_gain,
    input logic [31:0] centre_freq_word,
    input logic [9:0] out_sample_width,
    input logic out_signed,
    input logic out_resample_en,
    input logic [7:0] out_rate_msps,
    input logic out_if_reset,
    input logic interp_saturated,
    input logic saturation_probe_point
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // a control-space write to one register index
    sequence wr_at(logic [3:0] a);
        reg_wr_en && !reg_status_sel && reg_addr == a;
    endsequence
    chk_sat_probe: assert property (1'b1 |=> saturation_probe_point == $past(interp_saturated))
        else $error("saturation probe does not follow the filter flag");
    chk_addr_wr_pulse: assert property (wr_at(modcfg_pkg::ADDR_BUS_ADDR) |=> out_if_reset)
        else $error("address write gave no interface reset");
    chk_if_reset_src: assert property (out_if_reset |-> $past(reg_wr_en && !reg_status_sel
        && reg_addr == modcfg_pkg::ADDR_BUS_ADDR))
        else $error("interface reset without an address write");
    chk_gain_low: assert property (wr_at(modcfg_pkg::ADDR_GAIN_LO) |-> ##2
        signal_gain[7:0] == $past(reg_wr_data, 2)) else $error("gain low byte wrong");
    chk_freq_top: assert property (wr_at(modcfg_pkg::ADDR_FREQ_B3) |-> ##2
        centre_freq_word[31:24] == $past(reg_wr_data, 2)) else $error("freq top byte wrong");
    chk_osel_signed: assert property (wr_at(modcfg_pkg::ADDR_OUT_SEL) ##0
        reg_wr_data[2:0] == modcfg_pkg::OSEL_S14_50 |-> ##2 (out_signed && out_resample_en
        && out_sample_width == 10'd14 && out_rate_msps == modcfg_pkg::RATE_50))
        else $error("signed 14-bit format not applied");
    chk_osel_native: assert property (wr_at(modcfg_pkg::ADDR_OUT_SEL) ##0
        reg_wr_data[2:0] == modcfg_pkg::OSEL_U10_90 |-> ##2 (!out_signed && !out_resample_en
        && out_sample_width == 10'd10 && out_rate_msps == modcfg_pkg::RATE_90))
        else $error("native rate format not applied");
    chk_bit_spacing: assert property (mod_bit_valid |=> !mod_bit_valid)
        else $error("bits handed out back to back");
    chk_carrier_on: assert property (wr_at(modcfg_pkg::ADDR_INPUT_CTRL) ##0
        reg_wr_data[1:0] == modcfg_pkg::TEST_CARRIER |-> ##[1:2] carrier_only)
        else $error("carrier test mode not entered");
endmodule
bind modulator_config_status_regs modcfg_checker chk (.ref_clk, .reset, .reg_addr,
    .reg_status_sel, .reg_wr_en, .reg_wr_data, .mod_bit_valid, .carrier_only, .signal_gain,
    .centre_freq_word, .out_sample_width, .out_signed, .out_resample_en, .out_rate_msps,
    .out_if_reset, .interp_saturated, .saturation_probe_point);

// ---- dv/usb_source_model.sv ----
// host byte source: one-cycle strobes on ref_clk
// assumes the caller spaces bytes
`timescale 1ns/1ps
module usb_source_model (
    input wire logic ref_clk,
    output logic usb_byte_valid,
    output logic [7:0] usb_byte
);
    initial begin
        usb_byte_valid = 1'b0;
        usb_byte = 8'h00;
    end
    // strobe one byte, then show its inverse
    task automatic send(input logic [7:0] b);
        usb_byte_valid = 1'b1;
        usb_byte = b;
        @(posedge ref_clk) #1;
        usb_byte_valid = 1'b0;
        usb_byte = ~b;
        @(posedge ref_clk) #1;
    endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the modulator register bank
// assumes inputs change 1 ns after ref_clk rises
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, reset, reg_status_sel, reg_wr_en, reg_rd_en, sample_clk_in, sample_clk_in_req;
    logic bus_clk_in, bus_rwn, bus_data_oe_n, usb_byte_valid, mod_bit_ready, mod_bit;
    logic mod_bit_valid, carrier_only, out_signed, out_resample_en, out_if_reset, rd_d;
    logic interp_saturated, saturation_probe_point, trace_native_strobe, capture_start;
    logic capture_at_clk, capture_busy;
    logic [3:0] reg_addr, bus_addr;
    logic [7:0] reg_wr_data, reg_rd_data, data_in, usb_byte, out_rate_msps, trace_sample;
    logic [7:0] capture_decimation, capture_rd_data;
    logic [8:0] capture_rd_addr;
    logic [9:0] out_sample_width;
    logic [15:0] bus_data_in, bus_data_out, signal_gain;
    logic [31:0] centre_freq_word, v;
    logic [31:0] rd_q[$], bit_q[$];
    logic [7:0] cv[16];
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    localparam logic [19:0] FMT[3] = '{{10'd10, 2'b01, modcfg_pkg::RATE_40},
        {10'd14, 2'b11, modcfg_pkg::RATE_50}, {10'd10, 2'b00, modcfg_pkg::RATE_90}};
    modulator_config_status_regs dut (.*);
    usb_source_model src (.ref_clk, .usb_byte_valid, .usb_byte);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // toggling saturation flag for the probe
    always @(posedge ref_clk) #1 interp_saturated = interp_saturated !== 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic compare(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    // scoreboard: read data and bits
    always @(posedge ref_clk) begin
        if (rd_d) compare("reg_rd_data", rd_q.pop_front(), {24'h0, reg_rd_data});
        if (mod_bit_valid === 1'b1)
            compare("mod_bit", bit_q.size() ? bit_q.pop_front() : 32'hx, {31'h0, mod_bit});
        rd_d <= reg_rd_en;
    end
    // strobe drops for a cycle between calls
    task automatic wr(input logic st, input logic [3:0] a, input logic [7:0] d);
        {reg_status_sel, reg_addr, reg_wr_data, reg_wr_en} = {st, a, d, 1'b1};
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic st, input logic [3:0] a, input logic [7:0] e);
        {reg_status_sel, reg_addr, reg_rd_en} = {st, a, 1'b1};
        rd_q.push_back({24'h0, e});
        tick(1);
        reg_rd_en = 1'b0;
        tick(1);
    endtask
    // slow pins; released lines show the inverse
    task automatic pin_word(input logic [7:0] d);
        {data_in, sample_clk_in} = {d, 1'b1};
        tick(4);
        sample_clk_in = 1'b0;
        tick(4);
        data_in = ~d;
    endtask
    task automatic bus_word(input logic [3:0] a, input logic d);
        {bus_addr, bus_data_in, bus_clk_in} = {a, 14'h0, d, 1'b1, 1'b1};
        tick(4);
        bus_clk_in = 1'b0;
        tick(4);
        bus_data_in = ~bus_data_in;
    endtask
    task automatic drain();
        int k;
        for (k = 0; k < 200 && bit_q.size() != 0; k++) tick(1);
        if (k == 200) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reg_status_sel, reg_wr_en, reg_rd_en, sample_clk_in, bus_clk_in, bus_rwn} = '0;
        {reg_addr, reg_wr_data, data_in, bus_addr, bus_data_in} = '0;
        {mod_bit_ready, trace_native_strobe, capture_start} = '0;
        {capture_decimation, capture_at_clk, capture_rd_addr, trace_sample} = {18'h0, 8'h5a};
        reset = 1'b1;
        v = $urandom(32'h6f64);
        tick(16);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) rd(1'b1, i[3:0], 8'h00);
        for (int a = 5; a < 14; a++) begin
            cv[a] = 8'($urandom);
            if (a == 11) cv[a] = {8{cv[10][7]}};
            wr(1'b0, a[3:0], cv[a]);
        end
        for (int a = 5; a < 14; a++) rd(1'b0, a[3:0], cv[a]);
        compare("signal_gain", {16'h0, cv[7], cv[6]}, {16'h0, signal_gain});
        compare("freq_word", {cv[11], cv[10], cv[9], cv[8]}, centre_freq_word);
        for (int c = 0; c < 3; c++) begin
            wr(1'b0, modcfg_pkg::ADDR_OUT_SEL, c[7:0]);
            tick(2);
            compare("out_format", {12'h0, FMT[c]}, {12'h0, out_sample_width, out_signed,
                out_resample_en, out_rate_msps});
        end
        wr(1'b0, modcfg_pkg::ADDR_BUS_ADDR, 8'h03);
        // each source twice; foreign bus address ignored
        for (int s = 0; s < 4; s++) begin
            wr(1'b0, modcfg_pkg::ADDR_INPUT_CTRL, {2'b00, s[1:0], 4'h0});
            mod_bit_ready = 1'b1;
            for (int r = 0; r < 2; r++) begin
                v = $urandom;
                for (int b = 7; b >= 0; b--) if (b == 0 || s == 1 || s == 2) bit_q.push_back(v[b]);
                if (s == 2) src.send(v[7:0]);
                else if (s == 3) bus_word(4'h5, 1'b1);
                else pin_word(v[7:0]);
                if (s == 3) bus_word(r == 1 ? modcfg_pkg::BUS_BROADCAST : 4'h3, v[0]);
                drain();
            end
        end
        bus_rwn = 1'b1;
        bus_word(4'h3, 1'b0);
        compare("bus_reply", 32'h1, {15'h0, bus_data_oe_n, bus_data_out});
        wr(1'b0, modcfg_pkg::ADDR_INPUT_CTRL, 8'h12);
        pin_word(8'hff);
        tick(30);
        compare("carrier_only", 32'h1, {31'h0, carrier_only});
        wr(1'b0, modcfg_pkg::ADDR_INPUT_CTRL, 8'h00);
        wr(1'b1, modcfg_pkg::ADDR_USB_CNT_B0, 8'hff);
        for (int i = 0; i < 4; i++) rd(1'b1, i[3:0], i == 0 ? 8'h02 : 8'h00);
        {capture_at_clk, capture_start} = 2'b11;
        tick(1);
        capture_start = 1'b0;
        for (n = 0; n < 600 && capture_busy !== 1'b0; n++) tick(1);
        compare("capture_len", 32'h200, n);
        capture_rd_addr = 9'($urandom);
        tick(2);
        compare("capture_rd_data", 32'h5a, {24'h0, capture_rd_data});
        tally_and_finish();
    end
endmodule
